// >>> hw/rdc_pkg.sv
// constants and types shared by the lane configuration register bank
package rdc_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_LANE2_SIGNAL_DETECT_THRESHOLD   = 8'h20;
    localparam logic [7:0] ADDR_RSVD_LOW      = 8'h21;
    localparam logic [7:0] ADDR_RSVD_HIGH     = 8'h22;
    localparam logic [7:0] ADDR_LANE3_DETECT  = 8'h23;
    localparam logic [7:0] ADDR_LANE3_BOOST   = 8'h24;
    localparam logic [7:0] ADDR_LANE3_SWING   = 8'h25;
    localparam logic [7:0] ADDR_LANE3_STATUS  = 8'h26;

    localparam logic [7:0] RST_LANE2_SIGNAL_DETECT_THRESHOLD    = 8'h00;
    localparam logic [7:0] RST_LANE3_DETECT   = 8'h00;
    localparam logic [7:0] RST_LANE3_BOOST    = 8'h2f;
    localparam logic [7:0] RST_LANE3_SWING    = 8'had;

    // ****************************************
    // field positions
    // ****************************************
    localparam int SD_ASSERT_LSB    = 2;
    localparam int SD_DEASSERT_LSB  = 0;
    localparam int DETECT_LSB       = 2;
    localparam int SHORT_PROT_BIT   = 7;
    localparam int SWING_LSB        = 0;
    localparam int STATUS_TERM_BIT  = 7;

    // ****************************************
    // probe timing
    // ****************************************
    localparam int PROBE_INTERVAL_MS   = 12;
    localparam int CLK_KHZ             = 200000;
    localparam int PROBE_INTERVAL_CYC  = PROBE_INTERVAL_MS * CLK_KHZ;
    localparam int PROBE_LIMIT         = 50;
    localparam int TIMER_W             = 22;
    localparam int PROBE_CNT_W         = 6;

    typedef enum logic [1:0] {
        DET_HIZ   = 2'b00,
        DET_AUTO  = 2'b01,
        DET_LOOP  = 2'b10,
        DET_FORCE = 2'b11
    } rdc_mode_e;

    // gray order along hiz -> wait -> terminated, give-up off the side
    typedef enum logic [1:0] {
        ST_HIZ    = 2'b00,
        ST_WAIT   = 2'b01,
        ST_TERM   = 2'b11,
        ST_GAVEUP = 2'b10
    } rdc_state_e;

    typedef struct packed {
        logic [1:0] sd_assert;
        logic [1:0] sd_deassert;
        logic [7:0] boost_setting;
        logic       short_prot_en;
        logic [2:0] output_swing;
    } rdc_lane_cfg_s;

endpackage

// >>> hw/rdc_lane_regs.sv
// lane configuration registers with receiver presence probe sequencer
`timescale 1ns/100ps
module rdc_lane_regs #(
    parameter int PROBE_INTERVAL_CYC = rdc_pkg::PROBE_INTERVAL_CYC
) (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic                   reg_wr_en,
    input  wire logic [7:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    output logic      [7:0]             reg_rdata_q,
    input  wire logic                   override_signal_detect_threshold,
    input  wire logic                   override_detect,
    input  wire logic [3:0]             signal_detect_threshold_strap,
    input  wire logic [1:0]             detect_strap,
    input  wire logic                   far_end_found,
    output logic                        probe_pulse_q,
    output logic                        term_50ohm_q,
    output rdc_pkg::rdc_lane_cfg_s      lane_cfg_q
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [3:0] sd_strap_m_q;
    logic [3:0] sd_strap_q;
    logic [1:0] det_strap_m_q;
    logic [1:0] det_strap_q;
    logic       found_m_q;
    logic       found_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sd_strap_m_q  <= 4'h0;
            sd_strap_q    <= 4'h0;
            det_strap_m_q <= 2'h0;
            det_strap_q   <= 2'h0;
            found_m_q     <= 1'b0;
            found_q       <= 1'b0;
        end else begin
            sd_strap_m_q  <= signal_detect_threshold_strap;
            sd_strap_q    <= sd_strap_m_q;
            det_strap_m_q <= detect_strap;
            det_strap_q   <= det_strap_m_q;
            found_m_q     <= far_end_found;
            found_q       <= found_m_q;
        end
    end

    // ****************************************
    // register file
    // ****************************************
    logic [7:0] signal_detect_threshold_q;
    logic [7:0] detect_q;
    logic [7:0] boost_q;
    logic [7:0] swing_q;
    logic       detect_wr;

    assign detect_wr = reg_wr_en && (reg_addr == rdc_pkg::ADDR_LANE3_DETECT);

    // reserved bits are stored as written; swing bits 6:3 rely on the host writing 0101
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            signal_detect_threshold_q  <= rdc_pkg::RST_LANE2_SIGNAL_DETECT_THRESHOLD;
            detect_q <= rdc_pkg::RST_LANE3_DETECT;
            boost_q  <= rdc_pkg::RST_LANE3_BOOST;
            swing_q  <= rdc_pkg::RST_LANE3_SWING;
        end else if (reg_wr_en) begin
            if (reg_addr == rdc_pkg::ADDR_LANE2_SIGNAL_DETECT_THRESHOLD) begin
                signal_detect_threshold_q <= reg_wdata;
            end else if (reg_addr == rdc_pkg::ADDR_LANE3_DETECT) begin
                detect_q <= reg_wdata;
            end else if (reg_addr == rdc_pkg::ADDR_LANE3_BOOST) begin
                boost_q <= reg_wdata;
            end else if (reg_addr == rdc_pkg::ADDR_LANE3_SWING) begin
                swing_q <= reg_wdata;
            end
        end
    end

    // ****************************************
    // read path
    // ****************************************
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = 8'h00;
        if (reg_addr == rdc_pkg::ADDR_LANE2_SIGNAL_DETECT_THRESHOLD) begin
            rdata_d = signal_detect_threshold_q;
        end else if (reg_addr == rdc_pkg::ADDR_LANE3_DETECT) begin
            rdata_d = detect_q;
        end else if (reg_addr == rdc_pkg::ADDR_LANE3_BOOST) begin
            rdata_d = boost_q;
        end else if (reg_addr == rdc_pkg::ADDR_LANE3_SWING) begin
            rdata_d = swing_q;
        end else if (reg_addr == rdc_pkg::ADDR_LANE3_STATUS) begin
            rdata_d[rdc_pkg::STATUS_TERM_BIT] = term_50ohm_q;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_q <= 8'h00;
        end else begin
            reg_rdata_q <= rdata_d;
        end
    end

    // ****************************************
    // effective lane settings
    // ****************************************
    logic [3:0]          sd_src;
    rdc_pkg::rdc_mode_e  mode;
    rdc_pkg::rdc_mode_e  mode_q;

    assign sd_src = override_signal_detect_threshold ? signal_detect_threshold_q[3:0] : sd_strap_q;
    assign mode   = rdc_pkg::rdc_mode_e'(override_detect
                    ? detect_q[rdc_pkg::DETECT_LSB +: 2] : det_strap_q);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lane_cfg_q <= '0;
            mode_q     <= rdc_pkg::DET_HIZ;
        end else begin
            lane_cfg_q.sd_assert     <= sd_src[rdc_pkg::SD_ASSERT_LSB +: 2];
            lane_cfg_q.sd_deassert   <= sd_src[rdc_pkg::SD_DEASSERT_LSB +: 2];
            lane_cfg_q.boost_setting <= boost_q;
            lane_cfg_q.short_prot_en <= swing_q[rdc_pkg::SHORT_PROT_BIT];
            lane_cfg_q.output_swing  <= swing_q[rdc_pkg::SWING_LSB +: 3];
            mode_q                   <= mode;
        end
    end

    // ****************************************
    // probe sequencer
    // ****************************************
    localparam logic [rdc_pkg::TIMER_W-1:0] TIMER_LAST =
        rdc_pkg::TIMER_W'(PROBE_INTERVAL_CYC - 1);
    localparam logic [rdc_pkg::PROBE_CNT_W-1:0] PROBE_MAX =
        rdc_pkg::PROBE_CNT_W'(rdc_pkg::PROBE_LIMIT);

    rdc_pkg::rdc_state_e            state_q;
    logic [rdc_pkg::TIMER_W-1:0]    timer_q;
    logic [rdc_pkg::PROBE_CNT_W-1:0] probes_q;
    logic                           restart;
    logic                           tick;

    // a mode change from a strap or override counts as a rewrite too
    assign restart = detect_wr || (mode != mode_q);
    assign tick    = (timer_q == TIMER_LAST);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            timer_q <= '0;
        end else if (restart || tick || state_q != rdc_pkg::ST_WAIT) begin
            timer_q <= '0;
        end else begin
            timer_q <= timer_q + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q       <= rdc_pkg::ST_HIZ;
            probes_q      <= '0;
            probe_pulse_q <= 1'b0;
        end else begin
            probe_pulse_q <= 1'b0;
            if (restart) begin
                probes_q <= '0;
                case (mode)
                    rdc_pkg::DET_HIZ:   state_q <= rdc_pkg::ST_HIZ;
                    rdc_pkg::DET_FORCE: state_q <= rdc_pkg::ST_TERM;
                    default:            state_q <= rdc_pkg::ST_WAIT;
                endcase
            end else begin
                case (state_q)
                    rdc_pkg::ST_WAIT: begin
                        if (found_q) begin
                            state_q <= rdc_pkg::ST_TERM;
                        end else if (tick) begin
                            // limit hit after the 50th probe's interval: give up
                            if (mode == rdc_pkg::DET_AUTO && probes_q == PROBE_MAX) begin
                                state_q <= rdc_pkg::ST_GAVEUP;
                            end else begin
                                probe_pulse_q <= 1'b1;
                                if (mode == rdc_pkg::DET_AUTO) begin
                                    probes_q <= probes_q + 1'b1;
                                end
                            end
                        end
                    end
                    default: state_q <= state_q;
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            term_50ohm_q <= 1'b0;
        end else begin
            term_50ohm_q <= (state_q == rdc_pkg::ST_TERM);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    hiz_mode_a: assert property (
        mode == rdc_pkg::DET_HIZ [*3] |-> !term_50ohm_q)
        else $error("termination applied while detect mode is hiz");

    forced_term_a: assert property (
        mode == rdc_pkg::DET_FORCE [*3] |-> term_50ohm_q && !probe_pulse_q)
        else $error("forced mode did not terminate");

    // compare against the register as it stood at the launching edge, so writes do not trip it
    sd_select_a: assert property (
        override_signal_detect_threshold |=> lane_cfg_q.sd_assert == $past(signal_detect_threshold_q[3:2])
        && lane_cfg_q.sd_deassert == $past(signal_detect_threshold_q[1:0]))
        else $error("threshold register not applied under override");

    probe_limit_a: assert property (
        mode == rdc_pkg::DET_AUTO |-> probes_q <= PROBE_MAX)
        else $error("too many probes in limited mode");

    gave_up_quiet_a: assert property (
        state_q == rdc_pkg::ST_GAVEUP && !restart |=> !probe_pulse_q && !term_50ohm_q)
        else $error("probing or terminated after giving up");

    loop_forever_a: assert property (
        mode == rdc_pkg::DET_LOOP && !restart |=> state_q != rdc_pkg::ST_GAVEUP)
        else $error("unlimited mode gave up");

    detect_term_a: assert property (
        state_q == rdc_pkg::ST_WAIT && found_q && !restart |=> ##1 term_50ohm_q)
        else $error("detection did not terminate input");

    boost_write_a: assert property (
        reg_wr_en && reg_addr == rdc_pkg::ADDR_LANE3_BOOST |=>
        ##1 lane_cfg_q.boost_setting == $past(reg_wdata, 2))
        else $error("boost setting did not follow write");

    swing_out_a: assert property (
        $stable(swing_q) |=> lane_cfg_q.output_swing == $past(swing_q[2:0])
        && lane_cfg_q.short_prot_en == $past(swing_q[7]))
        else $error("swing fields not driven");

    timer_restart_a: assert property (
        detect_wr |=> timer_q == '0)
        else $error("probe timer not restarted");

    status_read_a: assert property (
        reg_addr == rdc_pkg::ADDR_LANE3_STATUS |=> reg_rdata_q == {$past(term_50ohm_q), 7'h00})
        else $error("status bit does not show termination");

    probe_one_cycle_a: assert property (
        probe_pulse_q |=> !probe_pulse_q)
        else $error("probe pulse longer than one cycle");

    probe_in_wait_a: assert property (
        state_q != rdc_pkg::ST_WAIT |=> !probe_pulse_q)
        else $error("probe issued outside the waiting state");

    loop_probe_due_a: assert property (
        state_q == rdc_pkg::ST_WAIT && mode == rdc_pkg::DET_LOOP
        && tick && !found_q && !restart |=> probe_pulse_q)
        else $error("unlimited mode skipped a probe");

    give_up_count_a: assert property (
        state_q == rdc_pkg::ST_WAIT ##1 state_q == rdc_pkg::ST_GAVEUP |->
        $past(probes_q) == PROBE_MAX)
        else $error("gave up before the probe limit");

    sd_strap_used_a: assert property (
        !override_signal_detect_threshold |=> lane_cfg_q.sd_assert == $past(sd_strap_q[3:2])
        && lane_cfg_q.sd_deassert == $past(sd_strap_q[1:0]))
        else $error("threshold strap not applied without override");

    strap_hiz_a: assert property (
        (!override_detect && det_strap_q == 2'b00) [*3] |-> !term_50ohm_q)
        else $error("strap hiz mode did not keep input open");

    detect_store_a: assert property (
        detect_wr |=> detect_q == $past(reg_wdata))
        else $error("detect register write lost");

    boost_read_a: assert property (
        reg_addr == rdc_pkg::ADDR_LANE3_BOOST |=> reg_rdata_q == $past(boost_q))
        else $error("boost register read wrong");

    swing_store_a: assert property (
        reg_wr_en && reg_addr == rdc_pkg::ADDR_LANE3_SWING |=> swing_q == $past(reg_wdata))
        else $error("swing register write lost");

    // a rise outside forced mode must come from a seen far end two edges earlier
    term_after_found_a: assert property (
        $rose(term_50ohm_q) && $past(mode_q) != rdc_pkg::DET_FORCE |-> $past(found_q, 2))
        else $error("termination without a detected receiver");

    timer_hold_a: assert property (
        state_q != rdc_pkg::ST_WAIT |=> timer_q == '0)
        else $error("probe timer running outside wait");

endmodule

// >>> test/rdc_far_end_model.sv
// far-end receiver model answering presence probes
`timescale 1ns/100ps
module rdc_far_end_model (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       probe_pulse_q,
    input  wire logic       present,
    input  wire logic [3:0] answer_delay,
    output logic            far_end_found
);
    logic [4:0] wait_q;
    // ********
    // probe answer
    // ********
    // answers only after a probe, never on its own
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_q        <= 5'h0;
            far_end_found <= 1'b0;
        end else if (!present) begin
            wait_q        <= 5'h0;
            far_end_found <= 1'b0;
        end else if (probe_pulse_q) begin
            wait_q <= {1'b0, answer_delay} + 5'h1;
        end else if (wait_q == 5'h1) begin
            wait_q        <= 5'h0;
            far_end_found <= 1'b1;
        end else if (wait_q != 5'h0) begin
            wait_q <= wait_q - 5'h1;
        end
    end
endmodule

// >>> test/rdc_lane_regs_bench.sv
// self-checking bench for the lane configuration register bank
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module rdc_lane_regs_bench;
    localparam int INT = 20;
    localparam logic [7:0] RSV [3] = '{8'h21, 8'h22, 8'h30};
    logic                   clk, sys_rst, wr, ovs, ovd, found, probe, term, present;
    logic [7:0]             addr, wdata, rdata, b, s, t;
    logic [3:0]             sd_strap, dly;
    logic [1:0]             det_strap;
    rdc_pkg::rdc_lane_cfg_s cfg;
    int                     fails, checks, cnt;

    rdc_lane_regs #(.PROBE_INTERVAL_CYC(INT)) dut (
        .clk(clk), .sys_rst(sys_rst), .reg_wr_en(wr), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata_q(rdata), .override_signal_detect_threshold(ovs),
        .override_detect(ovd), .signal_detect_threshold_strap(sd_strap), .detect_strap(det_strap),
        .far_end_found(found), .probe_pulse_q(probe), .term_50ohm_q(term),
        .lane_cfg_q(cfg));
    rdc_far_end_model far_end (
        .clk(clk), .sys_rst(sys_rst), .probe_pulse_q(probe), .present(present),
        .answer_delay(dly), .far_end_found(found));

    always #2.5 clk = ~clk;

    // ********
    // tasks and expectations
    // ********
    task automatic end_of_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // two negedges so back-to-back writes never touch the strobe twice at once
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        addr = a;
        @(negedge clk);
        `CHK(rdata, e)
    endtask

    function automatic int exp_probes(input logic [1:0] m, input logic p, input int n);
        if (m == 2'b00 || m == 2'b11) return 0;
        if (p) return 1;
        return (m == 2'b01 && n > 50) ? 50 : n;
    endfunction

    task automatic run_mode(input logic [1:0] m, input logic p, input int n);
        int   c, last, gap;
        logic et;
        present = 1'b0;
        wr_reg(8'h23, 8'h00);
        repeat (5) @(negedge clk);
        present = p;
        dly = 4'($urandom_range(7, 0));
        wr_reg(8'h23, {4'h0, m, 2'b00});
        c = 0;
        last = 0;
        gap = INT;
        for (int i = 1; i <= n * INT + 5; i++) begin
            @(negedge clk);
            if (probe === 1'b1) begin
                if (c > 0) gap = i - last;
                c++;
                last = i;
            end
        end
        et = (m == 2'b11) || (p && m != 2'b00);
        `CHK(c, exp_probes(m, p, n))
        `CHK(gap, INT)
        `CHK(term, et)
        rd_reg(8'h26, {et, 7'h0});
    endtask

    // ********
    // main sequence
    // ********
    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        {wr, addr, wdata, ovs, ovd, sd_strap, det_strap, present, dly} = '0;
        fails = 0;
        checks = 0;
        void'($urandom(32'h29d53b40));
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        rd_reg(8'h20, 8'h00);
        rd_reg(8'h23, 8'h00);
        rd_reg(8'h24, 8'h2f);
        rd_reg(8'h25, 8'had);
        `CHK(cfg.output_swing, 3'b101)
        foreach (RSV[k]) begin
            wr_reg(RSV[k], 8'($urandom));
            rd_reg(RSV[k], 8'h00);
        end
        for (int i = 0; i < 8; i++) begin
            b = 8'($urandom);
            s = {1'(i), 4'b0101, 3'(i)};
            t = 8'($urandom);
            sd_strap = 4'($urandom);
            ovs = 1'($urandom);
            wr_reg(8'h24, b);
            wr_reg(8'h25, s);
            wr_reg(8'h20, t);
            repeat (3) @(negedge clk);
            rd_reg(8'h24, b);
            rd_reg(8'h25, s);
            rd_reg(8'h20, t);
            `CHK(cfg.boost_setting, b)
            `CHK(cfg.short_prot_en, s[7])
            `CHK(cfg.output_swing, s[2:0])
            `CHK(cfg.sd_assert, ovs ? t[3:2] : sd_strap[3:2])
            `CHK(cfg.sd_deassert, ovs ? t[1:0] : sd_strap[1:0])
        end
        det_strap = 2'b11;
        wr_reg(8'h23, 8'h00);
        repeat (6) @(negedge clk);
        `CHK(term, 1'b1)
        det_strap = 2'b00;
        repeat (6) @(negedge clk);
        `CHK(term, 1'b0)
        ovd = 1'b1;
        for (int m = 0; m < 4; m++) begin
            run_mode(2'(m), 1'b0, 55);
            run_mode(2'(m), 1'b1, 55);
        end
        present = 1'b0;
        cnt = 0;
        // rewrites closer than one interval must keep the probe from firing
        repeat (5) begin
            wr_reg(8'h23, 8'h08);
            repeat (13) begin
                @(negedge clk);
                if (probe === 1'b1) cnt++;
            end
        end
        `CHK(cnt, 0)
        end_of_test();
    end

    initial begin
        #400000;
        fails++;
        end_of_test();
    end
endmodule
